// File: verilog/sadc_top.sv
// Notes on behaviour
// - Result is 12-bit straight binary; one step is reference over 4096.
// - Ideal codes: FFF near full scale, 800 midscale, 7FF below, 000 zero.
// - Analog section powers down once conversion completes, select still low.
// - Digital section fully off while idle: select high, or a start refused by a full buffer.
// - Select high ends a conversion at any point; device aborts to full power-down.
// - Each decided bit goes to the output at once, word not buffered first.
// - One bit decision per shift clock, output updated in the same cycle.
// - Select falling starts a frame; input sampled over first 1.5 to 2 clocks.
// - After second falling clock, drive low null bit, then 12 bits MSB first.
// - After LSB, resend bits 1 to 11 LSB first, LSB itself not repeated; after top bit again, output floats.
// - A new conversion needs select taken high and then low again.
`timescale 1ns/1ps
`default_nettype none
module sadc_top
    import sadc_pkg::*;
#(
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic                      mclk,
    input  wire logic                      sys_rst,
    input  wire logic                      clk_en,
    input  wire logic                      sel_n_pin,
    input  wire logic                      conversion_shift_clock,
    input  wire logic [sadc_pkg::RES_W-1:0] ana_code,
    output logic                           dout_o,
    output logic                           dout_oe,
    output logic                           analog_pd,
    output logic                           digital_pd,
    output logic      [sadc_pkg::RES_W-1:0] res_data,
    output logic                           res_valid,
    input  wire logic                      res_ready
);
    import sadc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic sel_s1_ff;
    logic sel_s2_ff;
    logic sclk_s1_ff;
    logic sclk_s2_ff;
    logic sclk_s3_ff;
    logic sclk_fall;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sel_s1_ff  <= 1'b1;
            sel_s2_ff  <= 1'b1;
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_s3_ff <= 1'b0;
        end else if (clk_en) begin
            sel_s1_ff  <= sel_n_pin;
            sel_s2_ff  <= sel_s1_ff;
            sclk_s1_ff <= conversion_shift_clock;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
        end
    end

    assign sclk_fall = sclk_s3_ff && !sclk_s2_ff;

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    sadc_state_t        state_ff;
    sadc_state_t        nxt_state;
    logic [CNT_W-1:0]   cnt_ff;
    logic [CNT_W-1:0]   nxt_cnt;
    logic [RES_W-1:0]   hold_ff;
    logic [RES_W-1:0]   nxt_hold;
    logic [RES_W-1:0]   sar_ff;
    logic [RES_W-1:0]   nxt_sar;
    logic               dout_ff;
    logic               nxt_dout;
    logic               oe_ff;
    logic               nxt_oe;
    logic               sel_arm_ff;
    logic               nxt_sel_arm;
    logic               push_valid;
    logic               push_ready;
    logic [CNT_W-1:0]   fall_no;
    logic [3:0]         bit_idx;
    logic [RES_W-1:0]   trial;

    assign fall_no = cnt_ff + CNT_W'(1);

    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_hold    = hold_ff;
        nxt_sar     = sar_ff;
        nxt_dout    = dout_ff;
        nxt_oe      = oe_ff;
        nxt_sel_arm = sel_arm_ff;
        push_valid  = 1'b0;
        bit_idx     = 4'(FALL_LSB - fall_no);
        trial       = sar_ff | (RES_W'(1) << bit_idx);
        if (sel_s2_ff) begin
            nxt_sel_arm = 1'b1;
        end
        if (sel_s2_ff && state_ff != ST_IDLE) begin
            nxt_state = ST_IDLE;
            nxt_oe    = 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_oe = 1'b0;
                    // A full result buffer refuses the start so no word is lost
                    if (!sel_s2_ff && sel_arm_ff && push_ready) begin
                        nxt_state   = ST_SAMPLE;
                        nxt_cnt     = '0;
                        nxt_sel_arm = 1'b0;
                    end
                end
                ST_SAMPLE: begin
                    if (sclk_fall) begin
                        nxt_cnt = fall_no;
                        if (fall_no == FALL_NULL) begin
                            nxt_hold  = ana_code;
                            nxt_sar   = '0;
                            nxt_oe    = 1'b1;
                            nxt_dout  = 1'b0;
                            nxt_state = ST_CONVERT;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (sclk_fall) begin
                        nxt_cnt = fall_no;
                        // Binary search against the held level gives straight binary
                        if (hold_ff >= trial) begin
                            nxt_sar  = trial;
                            nxt_dout = 1'b1;
                        end else begin
                            nxt_dout = 1'b0;
                        end
                        if (fall_no == FALL_LSB) begin
                            push_valid = 1'b1;
                            nxt_state  = ST_REPLAY;
                        end
                    end
                end
                ST_REPLAY: begin
                    if (sclk_fall) begin
                        nxt_cnt = fall_no;
                        if (fall_no == FALL_RELEASE) begin
                            nxt_oe    = 1'b0;
                            nxt_state = ST_DONE;
                        end else begin
                            nxt_dout = sar_ff[4'(fall_no - FALL_LSB)];
                        end
                    end
                end
                ST_DONE: begin
                    nxt_oe = 1'b0;
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_oe    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= '0;
            hold_ff    <= '0;
            sar_ff     <= '0;
            dout_ff    <= 1'b0;
            oe_ff      <= 1'b0;
            sel_arm_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            hold_ff    <= nxt_hold;
            sar_ff     <= nxt_sar;
            dout_ff    <= nxt_dout;
            oe_ff      <= nxt_oe;
            sel_arm_ff <= nxt_sel_arm;
        end
    end

    assign dout_o     = dout_ff;
    assign dout_oe    = oe_ff;
    // Analog runs only while sampling or deciding
    assign analog_pd  = !(state_ff == ST_SAMPLE || state_ff == ST_CONVERT);
    assign digital_pd = (state_ff == ST_IDLE);

    // ------------------------------------------------------------
    // Completed-word buffer
    // ------------------------------------------------------------
    sadc_fifo2 #(
        .W     (RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (nxt_sar),
        .out_valid (res_valid),
        .out_ready (res_ready),
        .out_data  (res_data)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_null_fall;
        clk_en && sclk_fall && !sel_s2_ff && state_ff == ST_SAMPLE && cnt_ff == 5'h01;
    endsequence

    sequence s_last_fall;
        clk_en && sclk_fall && !sel_s2_ff && state_ff == ST_REPLAY && cnt_ff == 5'h19;
    endsequence

    // The 25th fall carries the repeated top bit
    sequence s_top_fall;
        clk_en && sclk_fall && !sel_s2_ff && state_ff == ST_REPLAY && cnt_ff == 5'h18;
    endsequence

    a_float_sel_high: assert property (clk_en && sel_s2_ff |=> !dout_oe)
        else $error("output driven after select high");
    a_abort_to_idle: assert property (clk_en && sel_s2_ff |=> digital_pd && analog_pd)
        else $error("abort did not power down");
    a_null_bit: assert property (s_null_fall |=> dout_oe && !dout_o && state_ff == ST_CONVERT)
        else $error("null bit not driven low");
    a_msb_decision: assert property (clk_en && sclk_fall && !sel_s2_ff && state_ff == ST_CONVERT
                                     && cnt_ff == 5'h02 |=> dout_o == hold_ff[11])
        else $error("top bit decision wrong");
    a_code_exact: assert property (push_valid && clk_en |-> nxt_sar == hold_ff)
        else $error("result differs from held level");
    a_analog_off: assert property (push_valid && clk_en |=> analog_pd && !digital_pd)
        else $error("analog not off at completion");
    a_top_repeat: assert property (s_top_fall |=> dout_oe && dout_o == sar_ff[11])
        else $error("top bit not repeated");
    a_release_end: assert property (s_last_fall |=> !dout_oe)
        else $error("output not released after repeat");
    a_no_restart: assert property (clk_en && state_ff == ST_DONE && !sel_s2_ff
                                   |=> state_ff == ST_DONE)
        else $error("restart without select toggle");
    a_digital_on: assert property (clk_en && $fell(sel_s2_ff) && sel_arm_ff && push_ready
                                   |=> !digital_pd)
        else $error("digital stayed off after start");
endmodule
`default_nettype wire

// File: verilog/sadc_pkg.sv
`default_nettype none
package sadc_pkg;

    // ------------------------------------------------------------
    // Result coding
    // ------------------------------------------------------------
    localparam int          RES_W       = 12;
    localparam int          CODE_STEPS  = 4096;
    localparam logic [11:0] CODE_FULL   = 12'hfff;
    localparam logic [11:0] CODE_MID    = 12'h800;
    localparam logic [11:0] CODE_MID_M1 = 12'h7ff;
    localparam logic [11:0] CODE_ZERO   = 12'h000;

    // ------------------------------------------------------------
    // Falling-edge positions of the shift clock within a frame
    // ------------------------------------------------------------
    localparam int         CNT_W          = 5;
    localparam logic [4:0] FALL_NULL      = 5'h02;
    localparam logic [4:0] FALL_MSB       = 5'h03;
    localparam logic [4:0] FALL_LSB       = 5'h0e;
    localparam logic [4:0] FALL_TOP_AGAIN = 5'h19;
    localparam logic [4:0] FALL_RELEASE   = 5'h1a;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_SAMPLE  = 5'b00010,
        ST_CONVERT = 5'b00100,
        ST_REPLAY  = 5'b01000,
        ST_DONE    = 5'b10000
    } sadc_state_t;

endpackage
`default_nettype wire

// File: verilog/sadc_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo2 #(
    parameter int W     = 12,
    parameter int DEPTH = 2
) (
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    logic [AW-1:0] nxt_wr;
    logic [AW-1:0] nxt_rd;
    logic [AW:0]   nxt_cnt;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------
    always_comb begin
        nxt_wr  = wr_ff;
        nxt_rd  = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + AW'(1);
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + AW'(1);
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - (AW+1)'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else if (clk_en) begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge mclk) begin
        if (clk_en && push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
endmodule
`default_nettype wire

// File: bench/sadc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_model (
    input  wire logic mclk,
    output logic      sel_n_pin,
    output logic      conversion_shift_clock,
    input  wire logic dout_o,
    input  wire logic dout_oe
);
    // ------------------------------------------------------------
    // Line seen late after each falling edge, {oe, data}
    // ------------------------------------------------------------
    logic [1:0] line_q [1:26];

    // Shift clock stands low outside frames, select idles high
    initial begin
        sel_n_pin              = 1'b1;
        conversion_shift_clock = 1'b0;
    end

    // ------------------------------------------------------------
    // Link driving; callers enter at a rising mclk edge
    // ------------------------------------------------------------
    // 64 ns shift period; sampling late in the low phase leaves margin for the sync delay
    task automatic pump(input int n);
        for (int k = 1; k <= n; k++) begin
            conversion_shift_clock <= 1'b1;
            repeat (8) @(posedge mclk);
            conversion_shift_clock <= 1'b0;
            repeat (8) @(posedge mclk);
            // A released line carries no data, so its data bit is kept as 0
            line_q[k] = {dout_oe, dout_oe && dout_o};
        end
    endtask

    task automatic frame(input int n);
        sel_n_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        pump(n);
    endtask

    // Select high for one shift period ends or aborts the frame
    task automatic release_sel;
        sel_n_pin <= 1'b1;
        repeat (16) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// File: bench/sadc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_top_bench;
    import sadc_pkg::*;

    logic        mclk;
    logic        sys_rst;
    logic        clk_en;
    logic        sel_n_pin;
    logic        conversion_shift_clock;
    logic [11:0] ana_code;
    logic        dout_o;
    logic        dout_oe;
    logic        analog_pd;
    logic        digital_pd;
    logic [11:0] res_data;
    logic        res_valid;
    logic        res_ready;
    int          error_cnt;
    int          checked;
    int          cyc;

    sadc_top dut (
        .mclk                  (mclk),
        .sys_rst               (sys_rst),
        .clk_en                (clk_en),
        .sel_n_pin             (sel_n_pin),
        .conversion_shift_clock(conversion_shift_clock),
        .ana_code              (ana_code),
        .dout_o                (dout_o),
        .dout_oe               (dout_oe),
        .analog_pd             (analog_pd),
        .digital_pd            (digital_pd),
        .res_data              (res_data),
        .res_valid             (res_valid),
        .res_ready             (res_ready)
    );

    sadc_ctrl_model ctl (
        .mclk                  (mclk),
        .sel_n_pin             (sel_n_pin),
        .conversion_shift_clock(conversion_shift_clock),
        .dout_o                (dout_o),
        .dout_oe               (dout_oe)
    );

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic chk_line(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: line %b, want %b", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: word %h, want %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Null bit, MSB-first bits, LSB-first tail without bit 0, then release
    task automatic check_stream(input logic [11:0] c, input int n);
        chk_line(ctl.line_q[2], 2'b10);
        for (int k = 3; k <= n && k <= 14; k++) begin
            chk_line(ctl.line_q[k], {1'b1, c[14-k]});
        end
        for (int k = 15; k <= n && k <= 25; k++) begin
            chk_line(ctl.line_q[k], {1'b1, c[k-14]});
        end
        if (n == 26) chk_line(ctl.line_q[26], 2'b00);
    endtask

    // Looks at the buffer head mid-cycle, pops on the second rising edge after, returns settled
    task automatic pop(input logic [11:0] exp);
        int w;
        w = 0;
        @(negedge mclk);
        while (res_valid !== 1'b1 && w < 100) begin
            @(negedge mclk);
            w++;
        end
        chk_flag(res_valid, 1'b1);
        chk_word(res_data, exp);
        @(posedge mclk);
        res_ready <= 1'b1;
        @(posedge mclk);
        res_ready <= 1'b0;
        @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_codes;
        logic [11:0] codes [5];
        codes = '{CODE_FULL, CODE_MID, CODE_MID_M1, CODE_ZERO, 12'ha5c};
        foreach (codes[i]) begin
            ana_code <= codes[i];
            ctl.frame(26);
            check_stream(codes[i], 26);
            chk_flag(analog_pd, 1'b1);
            chk_flag(digital_pd, 1'b0);
            ctl.release_sel();
            chk_flag(digital_pd, 1'b1);
            chk_flag(dout_oe, 1'b0);
            pop(codes[i]);
        end
        $display("codes test done");
    endtask

    // Short cycle after the 8th result bit
    task automatic t_abort;
        ana_code <= 12'h3c9;
        ctl.frame(10);
        check_stream(12'h3c9, 10);
        ctl.release_sel();
        chk_flag(dout_oe, 1'b0);
        chk_flag(digital_pd, 1'b1);
        chk_flag(analog_pd, 1'b1);
        chk_flag(res_valid, 1'b0);
        $display("abort test done");
    endtask

    // Extra clocks with select low change nothing; a toggle restarts
    task automatic t_hold_low;
        ana_code <= 12'h6b1;
        ctl.frame(26);
        ana_code <= 12'h19e;
        ctl.pump(6);
        for (int k = 1; k <= 6; k++) chk_line({ctl.line_q[k][1], 1'b0}, 2'b00);
        ctl.release_sel();
        pop(12'h6b1);
        chk_flag(res_valid, 1'b0);
        ctl.frame(26);
        check_stream(12'h19e, 26);
        ctl.release_sel();
        pop(12'h19e);
        $display("hold low test done");
    endtask

    // Two words fill the buffer; a third start is refused, then drain
    task automatic t_buffer;
        for (int i = 0; i < 3; i++) begin
            ana_code <= 12'h101 + 12'(i);
            ctl.frame(4);
            chk_flag(ctl.line_q[2][1], i < 2 ? 1'b1 : 1'b0);
            ctl.pump(22);
            ctl.release_sel();
        end
        pop(12'h101);
        pop(12'h102);
        chk_flag(res_valid, 1'b0);
        $display("buffer test done");
    endtask

    // Low enable freezes the sequencer even across a select rise
    task automatic t_freeze;
        ana_code <= 12'h5a3;
        ctl.frame(26);
        clk_en <= 1'b0;
        ctl.release_sel();
        chk_flag(digital_pd, 1'b0);
        clk_en <= 1'b1;
        repeat (4) @(posedge mclk);
        chk_flag(digital_pd, 1'b1);
        chk_flag(dout_oe, 1'b0);
        pop(12'h5a3);
        $display("freeze test done");
    endtask

    // ------------------------------------------------------------
    // Clock, reset, timeout and sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("unexpected at %0t: run did not finish", $time);
            stop_test();
        end
    end

    initial begin
        sys_rst   = 1'b1;
        clk_en    = 1'b1;
        ana_code  = 12'h000;
        res_ready = 1'b0;
        error_cnt = 0;
        checked   = 0;
        cyc       = 0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_codes();
        t_abort();
        t_hold_low();
        t_buffer();
        t_freeze();
        stop_test();
    end
endmodule
`default_nettype wire
